/* oim_link_model.sv */
`timescale 1ns/1ps
module oim_link_model
  import oim_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire oim_rxcmd_t rxcmd,
  output int ev_cnt,
  output int alt_cnt
);
  // ==========================================================
  // Event intake.
  // The link only counts receive commands here; it reads status later over
  // the bus, and would start on session presence, not on power good.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_cnt <= 0;
      alt_cnt <= 0;
    end else begin
      if (rxcmd.event_seen === 1'b1) ev_cnt <= ev_cnt + 1;
      if ((rxcmd.event_seen & rxcmd.alt_int) === 1'b1) begin
        alt_cnt <= alt_cnt + 1;
      end
    end
  end
endmodule

/* oim_monitor.sv */
`timescale 1ns/1ps
module oim_monitor
  import oim_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic id_grounded_raw,
  input wire logic id_floating_raw,
  input wire logic [2:0] rid_code_raw,
  input wire logic session_ended_raw,
  input wire logic session_present_raw,
  input wire logic bus_power_good_raw,
  output logic id_pin_pullup_enable,
  output logic power_line_drain_enable,
  output logic power_line_pulse_enable,
  output oim_rxcmd_t rxcmd
);
  if (SYNC_STAGES != 2) begin : g_bad
    $error("oim_monitor supports exactly two sync stages");
  end

  // ==========================================================
  // Input synchronisers; the code bits are not captured as one word,
  // so software should read the code only after it has settled.
  logic [7:0] raw_w;
  logic [7:0] meta_q;
  logic [7:0] sync_q;
  assign raw_w = {rid_code_raw, id_grounded_raw, session_ended_raw,
                  session_present_raw, bus_power_good_raw, id_floating_raw};
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end else begin
      meta_q <= raw_w;
      sync_q <= meta_q;
    end
  end

  // ==========================================================
  // Control registers.
  logic [4:0] ctrl_q;
  logic [4:0] en_rise_q;
  logic [4:0] en_fall_q;
  logic [1:0] car_en_q;
  logic [2:0] ext_q;

  // ==========================================================
  // Status with comparator disable.
  logic send_on_w;
  logic vbus_on_w;
  logic [4:0] stat_w;
  logic [4:0] prev_q;
  logic [4:0] rise_w;
  logic [4:0] fall_w;
  logic [4:0] en_r_w;
  logic [4:0] en_f_w;
  logic [4:0] hit_w;
  assign send_on_w = en_rise_q[OIM_B_SEND] | en_fall_q[OIM_B_SEND];
  assign vbus_on_w = en_rise_q[OIM_B_VBUS] | en_fall_q[OIM_B_VBUS];
  assign stat_w[OIM_B_FLOAT] = sync_q[0];
  assign stat_w[OIM_B_VBUS] = sync_q[1] & vbus_on_w;
  // One combined comparator, never gated by its enables.
  assign stat_w[OIM_B_SESS] = sync_q[2];
  assign stat_w[OIM_B_SEND] = sync_q[3] & send_on_w;
  // A ground resistor pulls this low even with the pull-up off.
  assign stat_w[OIM_B_GND] = sync_q[4];
  assign rise_w = stat_w & ~prev_q;
  assign fall_w = ~stat_w & prev_q;
  assign en_r_w = {en_rise_q[4:1], car_en_q[OIM_B_FLOAT]};
  assign en_f_w = {en_fall_q[4:1], car_en_q[OIM_B_CAR_FALL]};
  assign hit_w = (rise_w & en_r_w) | (fall_w & en_f_w);

  // ==========================================================
  // Vbus valid source for the receive command.
  logic use_w;
  logic pass_w;
  logic comp_w;
  logic src_w;
  assign use_w = ext_q[OIM_B_USE];
  assign pass_w = ext_q[OIM_B_PASS];
  assign comp_w = ext_q[OIM_B_COMP];
  assign src_w = !use_w ? stat_w[OIM_B_VBUS] :
                 pass_w ? (OIM_EXT_IND ^ comp_w) :
                 (comp_w ? 1'b0 : stat_w[OIM_B_VBUS]);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= 5'h00;
      rxcmd <= '0;
    end else begin
      prev_q <= stat_w;
      rxcmd.event_seen <= |hit_w;
      rxcmd.alt_int <= hit_w[OIM_B_FLOAT];
      rxcmd.power_good <= src_w;
    end
  end

  // ==========================================================
  // AHB-Lite slave. Reads take one wait state so the data comes from a
  // flop and always sees a write that finished just before.
  logic take_w;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic mapped_w;
  logic [31:0] rmux_w;
  assign take_w = hsel & hready & htrans[1];
  assign mapped_w = (addr_q[1:0] == 2'b00) && (addr_q <= OIM_RID);
  always_comb begin
    rmux_w = 32'h0000_0000;
    unique case (addr_q)
      OIM_OTG_CTRL: rmux_w[4:0] = ctrl_q;
      OIM_EN_RISE: rmux_w[4:0] = en_rise_q;
      OIM_EN_FALL: rmux_w[4:0] = en_fall_q;
      OIM_INT_STAT: rmux_w[4:0] = {stat_w[4:1], 1'b0};
      OIM_CAR_STAT: rmux_w[0] = stat_w[OIM_B_FLOAT];
      OIM_CAR_EN: rmux_w[1:0] = car_en_q;
      OIM_EXT_CTRL: rmux_w[2:0] = ext_q;
      OIM_RID: rmux_w[2:0] = sync_q[7:5];
      default: rmux_w = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= take_w & hwrite;
      rd_pend_q <= take_w & !hwrite;
      hresp <= 1'b0;
      if (take_w) begin
        addr_q <= haddr[7:0] & {8{haddr[31:8] == 24'h000000}};
        if (haddr[31:8] != 24'h000000) begin
          addr_q <= 8'hff;
        end
      end
      hreadyout <= !(take_w & !hwrite);
      if (rd_pend_q) begin
        hrdata <= mapped_w ? rmux_w : 32'h0000_0000;
      end
    end
  end

  logic wr_w;
  assign wr_w = wr_pend_q & mapped_w;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= OIM_CTRL_RST;
      en_rise_q <= OIM_EN_RST;
      en_fall_q <= OIM_EN_RST;
      car_en_q <= OIM_CAR_EN_RST;
      ext_q <= OIM_EXT_RST;
    end else if (wr_w) begin
      if (addr_q == OIM_OTG_CTRL) ctrl_q <= hwdata[4:0];
      if (addr_q == OIM_EN_RISE) en_rise_q <= {hwdata[4:1], 1'b0};
      if (addr_q == OIM_EN_FALL) en_fall_q <= {hwdata[4:1], 1'b0};
      if (addr_q == OIM_CAR_EN) car_en_q <= hwdata[1:0];
      if (addr_q == OIM_EXT_CTRL) ext_q <= hwdata[2:0];
    end
  end

  // ==========================================================
  // Pin controls.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      id_pin_pullup_enable <= 1'b0;
      power_line_drain_enable <= 1'b0;
      power_line_pulse_enable <= 1'b0;
    end else begin
      id_pin_pullup_enable <= ctrl_q[OIM_B_PULLUP];
      power_line_drain_enable <= ctrl_q[OIM_B_DRAIN];
      power_line_pulse_enable <= ctrl_q[OIM_B_PULSE];
    end
  end

  // ==========================================================
  // Assertions.
  default clocking oim_cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  gnd_irq_a: assert property (
    rise_w[OIM_B_GND] && en_rise_q[OIM_B_GND] |=> rxcmd.event_seen)
    else $error("ID ground rise did not raise an event.");
  gnd_fall_a: assert property (
    fall_w[OIM_B_GND] && en_fall_q[OIM_B_GND] |=> rxcmd.event_seen)
    else $error("ID ground fall did not raise an event.");
  float_alt_a: assert property (
    (rise_w[0] && car_en_q[0]) || (fall_w[0] && car_en_q[1])
    |=> rxcmd.alt_int && rxcmd.event_seen)
    else $error("ID float change lost its alternate flag.");
  edge_gate_a: assert property (
    rxcmd.event_seen |-> $past((rise_w & en_r_w) != 5'h00 ||
                               (fall_w & en_f_w) != 5'h00))
    else $error("Event without an enabled edge.");
  send_off_a: assert property (
    !en_rise_q[OIM_B_SEND] && !en_fall_q[OIM_B_SEND]
    |=> !prev_q[OIM_B_SEND] || en_rise_q[OIM_B_SEND] ||
        en_fall_q[OIM_B_SEND])
    else $error("Disabled session end reads one.");
  vbus_off_a: assert property (
    !vbus_on_w && rd_pend_q && addr_q == OIM_INT_STAT
    |=> hrdata[OIM_B_VBUS] == 1'b0)
    else $error("Disabled vbus valid read as one.");
  sess_keep_a: assert property (
    rd_pend_q && addr_q == OIM_INT_STAT
    |=> hrdata[OIM_B_SESS] == $past(sync_q[2]))
    else $error("Session valid status not readable.");
  gnd_read_a: assert property (
    rd_pend_q && addr_q == OIM_INT_STAT
    |=> hrdata[OIM_B_GND] == $past(id_grounded_raw, 3))
    else $error("ID ground status wrong at bit 4.");
  vsrc_fix_a: assert property (
    use_w && pass_w && $stable(ext_q) |=> rxcmd.power_good == !$past(comp_w))
    else $error("Fixed vbus valid source wrong.");
  read_wait_a: assert property (
    take_w && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state missing.");
  drain_a: assert property (
    wr_w && addr_q == OIM_OTG_CTRL |=> ##1
    power_line_drain_enable == $past(hwdata[OIM_B_DRAIN], 2))
    else $error("Discharge control not following bit 3.");

  gnd_cov_c: cover property (rise_w[OIM_B_GND] ##1 rxcmd.event_seen);
  float_cov_c: cover property (rxcmd.alt_int);
  ext_cov_c: cover property (use_w && !pass_w && comp_w ##1
                             !rxcmd.power_good);
endmodule

/* oim_pkg.sv */
// What this block does
// - ID-ground status reads 0 for a grounded ID pin, 1 when floating.
// - ID resistance code: ground 000 up to floating 101, pull-up off.
// - The ID resistance code is readable while in synchronous mode.
// - Without pull-up, an attached ground resistor drops ID-ground and may interrupt.
// - Enabled ID-float changes produce a receive command with alternate bit.
// - ID-ground status sits at bit 4 of the interrupt status register.
// - ID-float status sits at bit 0 of the carkit interrupt status.
// - Enabled ID-ground changes raise an interrupt.
// - Session end, session valid and vbus valid states are readable.
// - Session-end status goes 0 to 1 when Vbus drops below 0.5 V.
// - Both session-end enables clear disables it; status reads 0.
// - Both session-valid enables clear only stops its interrupts.
// - Both vbus-valid enables clear disables it; status bit 1 reads 0.
// - One session-valid indication serves both A and B roles.
// - External vbus indication is fixed one; its logic is off by default.
// - Receive-command vbus-valid source follows use, pass and complement bits.
// - OTG control bit 3 drives Vbus discharge, bit 4 Vbus charge.
package oim_pkg;
  // ==========================================================
  // Register map, byte addresses.
  localparam logic [7:0] OIM_OTG_CTRL = 8'h00;
  localparam logic [7:0] OIM_EN_RISE = 8'h04;
  localparam logic [7:0] OIM_EN_FALL = 8'h08;
  localparam logic [7:0] OIM_INT_STAT = 8'h0c;
  localparam logic [7:0] OIM_CAR_STAT = 8'h10;
  localparam logic [7:0] OIM_CAR_EN = 8'h14;
  localparam logic [7:0] OIM_EXT_CTRL = 8'h18;
  localparam logic [7:0] OIM_RID = 8'h1c;
  // ==========================================================
  // Field positions.
  localparam int OIM_B_PULLUP = 0;
  localparam int OIM_B_DRAIN = 3;
  localparam int OIM_B_PULSE = 4;
  localparam int OIM_B_FLOAT = 0;
  localparam int OIM_B_VBUS = 1;
  localparam int OIM_B_SESS = 2;
  localparam int OIM_B_SEND = 3;
  localparam int OIM_B_GND = 4;
  localparam int OIM_B_CAR_FALL = 1;
  localparam int OIM_B_USE = 0;
  localparam int OIM_B_PASS = 1;
  localparam int OIM_B_COMP = 2;
  // ==========================================================
  // Reset values.
  localparam logic [4:0] OIM_CTRL_RST = 5'h00;
  localparam logic [4:0] OIM_EN_RST = 5'h1e;
  localparam logic [1:0] OIM_CAR_EN_RST = 2'h0;
  localparam logic [2:0] OIM_EXT_RST = 3'h0;
  localparam logic OIM_EXT_IND = 1'b1;
  // ==========================================================
  // Receive command event toward the link.
  typedef struct packed {
    logic event_seen;
    logic alt_int;
    logic power_good;
  } oim_rxcmd_t;
endpackage

/* testbench.sv */
`timescale 1ns/1ps
module testbench
  import oim_pkg::*;
;
  logic ref_clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic pu, dr, pl;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, rid;
  logic [4:0] raw;
  oim_rxcmd_t rxcmd;
  int errors, num_checks, seed, ev, alt;

  oim_monitor #(.SYNC_STAGES(2)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .id_grounded_raw(raw[4]),
    .id_floating_raw(raw[0]), .rid_code_raw(rid),
    .session_ended_raw(raw[3]), .session_present_raw(raw[2]),
    .bus_power_good_raw(raw[1]), .id_pin_pullup_enable(pu),
    .power_line_drain_enable(dr), .power_line_pulse_enable(pl),
    .rxcmd(rxcmd));
  oim_link_model link (.ref_clk(ref_clk), .reset_n(reset_n), .rxcmd(rxcmd),
    .ev_cnt(ev), .alt_cnt(alt));

  // ==========================================================
  // Checking helpers.
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Masked comparators read 0 once both of their enables are cleared.
  function automatic logic [31:0] stat_exp(logic on, logic [4:0] r);
    return {27'h0, r[4], r[3] & on, r[2], r[1] & on, 1'b0};
  endfunction
  function automatic logic vsrc(logic [2:0] x, logic v);
    if (!x[0]) return v;
    if (x[1]) return ~x[2];
    return x[2] ? 1'b0 : v;
  endfunction
  function automatic logic [31:0] rst_val(int i);
    return (i == 1 || i == 2) ? 32'h1e : 32'h0;
  endfunction

  // ==========================================================
  // Bus master: single word transfers, waits on hready each phase.
  task automatic bus_xfer(logic [7:0] a, logic w, logic [31:0] wd,
                          output logic [31:0] rdat);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    chk("response", 32'h0, {31'h0, hresp});
  endtask
  task automatic step(int b, logic v, int e_exp, int a_exp);
    int c0, a0;
    c0 = ev;
    a0 = alt;
    raw[b] <= v;
    repeat (8) @(posedge ref_clk);
    chk("events", 32'(e_exp), 32'(ev - c0));
    chk("alt events", 32'(a_exp), 32'(alt - a0));
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // The whole sequence needs about 500 cycles; this is ample.
  initial begin
    #200000;
    errors++;
    wrap_up();
  end

  initial begin
    seed = 75473;
    errors = 0;
    num_checks = 0;
    reset_n = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    raw = 5'h00;
    rid = 3'h0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      bus_xfer(8'(i * 4), 1'b0, 32'h0, rd);
      chk("reset value", rst_val(i), rd);
    end
    $display("reset test done");
    for (int k = 0; k < 2; k++) begin
      bus_xfer(OIM_OTG_CTRL, 1'b1, k ? 32'h08 : 32'h19, rd);
      repeat (3) @(posedge ref_clk);
      chk("pins", k ? 32'h08 : 32'h19, {27'h0, pl, dr, 2'h0, pu});
    end
    $display("control pin test done");
    for (int n = 0; n < 12; n++) begin
      if (n == 6) begin
        bus_xfer(OIM_EN_RISE, 1'b1, 32'h0, rd);
        bus_xfer(OIM_EN_FALL, 1'b1, 32'h0, rd);
      end
      raw <= (n == 0 || n == 6) ? 5'h1f : 5'($random(seed));
      rid <= 3'($unsigned($random(seed)) % 6);
      repeat (6) @(posedge ref_clk);
      bus_xfer(OIM_INT_STAT, 1'b0, 32'h0, rd);
      chk("int status", stat_exp(n < 6, raw), rd);
      bus_xfer(OIM_CAR_STAT, 1'b0, 32'h0, rd);
      chk("float status", {31'h0, raw[0]}, rd);
      bus_xfer(OIM_RID, 1'b0, 32'h0, rd);
      chk("rid code", {29'h0, rid}, rd);
    end
    $display("status test done");
    raw <= 5'h00;
    bus_xfer(OIM_EN_RISE, 1'b1, 32'h10, rd);
    bus_xfer(OIM_CAR_EN, 1'b1, 32'h0, rd);
    repeat (8) @(posedge ref_clk);
    step(4, 1'b1, 1, 0);
    step(4, 1'b0, 0, 0);
    bus_xfer(OIM_EN_FALL, 1'b1, 32'h10, rd);
    step(4, 1'b1, 1, 0);
    step(4, 1'b0, 1, 0);
    step(1, 1'b1, 0, 0);
    bus_xfer(OIM_CAR_EN, 1'b1, 32'h3, rd);
    step(0, 1'b1, 1, 1);
    step(0, 1'b0, 1, 1);
    bus_xfer(OIM_CAR_EN, 1'b1, 32'h0, rd);
    step(0, 1'b1, 0, 0);
    $display("event test done");
    bus_xfer(OIM_EN_RISE, 1'b1, 32'h1e, rd);
    bus_xfer(OIM_EN_FALL, 1'b1, 32'h1e, rd);
    for (int k = 0; k < 16; k++) begin
      bus_xfer(OIM_EXT_CTRL, 1'b1, {29'h0, 3'(k >> 1)}, rd);
      raw[1] <= k[0];
      repeat (8) @(posedge ref_clk);
      chk("power good", {31'h0, vsrc(3'(k >> 1), k[0])},
          {31'h0, rxcmd.power_good});
    end
    $display("source select test done");
    wrap_up();
  end
endmodule
